// ===== hdl/vector_type_reinterpret.sv
// Purpose: relabel the numeric type of every lane of a vector, bits untouched
// Assumes: inputs synchronous to clk; config held steady or changed between words
// Notes: a 32-word buffer sits in the data path; outputs are registered
`include "vtr_regs.svh"

// ****************************************
// buffer
// ****************************************
module vtr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic ready_ff, nxt_ready;
  logic push, pop;

  assign push = in_valid && ready_ff;
  assign pop = out_valid && out_ready;
  assign in_ready = ready_ff;
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];

  always_comb begin
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // ready is registered so the source sees no path through the count adder
    nxt_ready = (nxt_count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      ready_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      ready_ff <= nxt_ready;
    end
  end

  // storage has no reset: contents are only read once written
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // a full buffer must refuse, else the next push overwrites the oldest word
  AST_FULL_REFUSE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    count_ff == (AW+1)'(DEPTH) |-> !ready_ff)
    else $error("full buffer still ready");
endmodule

// ****************************************
// top
// ****************************************
// Operation
// (RULE1) Every bit of each input lane reaches the matching output lane unchanged; only the label moves.
// (RULE2) Each output lane has exactly the same bit width as its input lane under every setting.
// (RULE3) Unsigned lanes may be labelled signed and signed lanes unsigned with the bits kept intact.
// (RULE4) With the type override on the output takes the chosen type, otherwise it keeps the input type.
// (RULE5) With the point override on the output point is the configured one, otherwise the input's.
// (RULE6) The configuring side must give a forced point between zero and the lane width inclusive.
// (RULE7) A whole vector of lanes is accepted per sample period and every lane is reinterpreted.
// (RULE8) One set of type settings applies to all lanes, and lanes never interact.
module vector_type_reinterpret
  import vtr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire reint_cfg_t cfg,
  input wire logic in_valid,
  output logic in_ready,
  input wire vec_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output vec_word_t out_word,
  output logic bpt_range_err
);
  vec_word_t tagged_w;
  vec_word_t fifo_data;
  logic fifo_valid, fifo_ready, fifo_in_ready;
  logic out_valid_ff, nxt_out_valid;
  vec_word_t out_word_ff, nxt_out_word;
  logic err_ff, nxt_err;
  logic load;

  // ****************************************
  // relabel stage
  // ****************************************
  function automatic fmt_t pick_fmt(input reint_cfg_t c, input fmt_t f);
    fmt_t r;
    r.arith = c.force_arith ? c.out_arith : f.arith; // [RULE4] [RULE3]
    r.bpt = c.force_bpt ? c.out_bpt : f.bpt; // [RULE5]
    return r;
  endfunction

  // one label for the whole vector; lanes are plain copies
  assign tagged_w.fmt = pick_fmt(cfg, in_word.fmt); // [RULE8]
  for (genvar g = 0; g < `VTR_LANES; g++) begin : g_lane
    assign tagged_w.lane[g] = in_word.lane[g]; // [RULE1] [RULE2] [RULE7]
  end

  vtr_fifo #(
    .W($bits(vec_word_t)),
    .DEPTH(`VTR_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_ready(fifo_in_ready),
    .in_data(tagged_w),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // ****************************************
  // output register and status
  // ****************************************
  assign load = !out_valid_ff || out_ready;
  assign fifo_ready = load;

  always_comb begin
    nxt_out_valid = load ? fifo_valid : out_valid_ff;
    nxt_out_word = (load && fifo_valid) ? fifo_data : out_word_ff;
    // out-of-range forced points are flagged, not clamped: clamping would change scaling silently
    nxt_err = cfg.force_bpt && (cfg.out_bpt > `VTR_BPT_MAX); // [RULE6]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_word_ff <= '0;
      err_ff <= 1'b0;
    end else begin
      out_valid_ff <= nxt_out_valid;
      out_word_ff <= nxt_out_word;
      err_ff <= nxt_err;
    end
  end

  // ready is the buffer's own flop, so no gate sits between it and the pin
  assign in_ready = fifo_in_ready;
  assign out_valid = out_valid_ff;
  assign out_word = out_word_ff;
  assign bpt_range_err = err_ff;

  // ****************************************
  // checks
  // ****************************************
  sequence s_stall;
    out_valid_ff && !out_ready;
  endsequence

  sequence s_held;
    out_valid_ff && $stable(out_word_ff);
  endsequence

  AST_BITS_KEPT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    tagged_w.lane == in_word.lane)
    else $error("lane bits altered");

  AST_WIDTH_SAME: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    $bits(out_word.lane) == $bits(in_word.lane))
    else $error("lane width changed");

  AST_SIGN_SWAP: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    cfg.force_arith && in_word.fmt.arith == ARITH_SIGNED && cfg.out_arith == ARITH_UNSIGNED
    |-> tagged_w.fmt.arith == ARITH_UNSIGNED && tagged_w.lane == in_word.lane)
    else $error("signed to unsigned relabel failed");

  AST_UNS_TO_SGN: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    cfg.force_arith && in_word.fmt.arith == ARITH_UNSIGNED && cfg.out_arith == ARITH_SIGNED
    |-> tagged_w.fmt.arith == ARITH_SIGNED && tagged_w.lane == in_word.lane)
    else $error("unsigned to signed relabel failed");

  AST_ARITH_FORCE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    cfg.force_arith |-> tagged_w.fmt.arith == cfg.out_arith)
    else $error("forced type not applied");

  AST_ARITH_KEEP: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    !cfg.force_arith |-> tagged_w.fmt.arith == in_word.fmt.arith)
    else $error("input type not kept");

  AST_BPT_SEL: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    tagged_w.fmt.bpt == (cfg.force_bpt ? cfg.out_bpt : in_word.fmt.bpt))
    else $error("binary point wrong");

  AST_BPT_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    cfg.force_bpt && cfg.out_bpt > `VTR_BPT_MAX |=> bpt_range_err)
    else $error("range error not flagged");

  AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    !(cfg.force_bpt && cfg.out_bpt > `VTR_BPT_MAX) |=> !bpt_range_err)
    else $error("range error without cause");

  // the output register must copy the buffer head bit for bit
  AST_LOAD_COPY: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    load && fifo_valid |=> out_word_ff == $past(fifo_data))
    else $error("output word differs from buffer head");

  AST_OUT_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    s_stall |=> s_held)
    else $error("output changed while stalled");

  AST_FIRST_OUT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    in_valid && in_ready && !out_valid_ff && !fifo_valid |-> ##2 out_valid_ff)
    else $error("word did not reach output in two cycles");

  for (genvar a = 0; a < `VTR_LANES; a++) begin : g_chk
    AST_LANE_ALONE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
      $changed(in_word.lane[a]) |-> tagged_w.lane[a] == in_word.lane[a])
      else $error("lane disturbed");
  end
endmodule

// ===== hdl/vtr_regs.svh
// Purpose: constants for the vector type reinterpret lane block
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes: widths are fixed, not parameters
`ifndef VTR_REGS_SVH
`define VTR_REGS_SVH
// ****************************************
// element and vector shape
// ****************************************
`define VTR_ELEM_W 16
`define VTR_LANES 4
`define VTR_BPT_W 5
`define VTR_BPT_MAX 5'h10
// ****************************************
// buffering
// ****************************************
`define VTR_FIFO_DEPTH 32
// ****************************************
// reset values
// ****************************************
`define VTR_BPT_RST 5'h00
`endif

// ===== hdl/vtr_pkg.sv
// Purpose: types for the vector type reinterpret lane block
// Assumes: constants come from vtr_regs.svh
// Notes: the format label travels beside the data through the buffer
`include "vtr_regs.svh"
package vtr_pkg;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ARITH_UNSIGNED, ARITH_SIGNED, ARITH_FLOAT} arith_t;
  typedef logic [`VTR_ELEM_W-1:0] lane_t;
  typedef struct packed {
    arith_t arith;
    logic [`VTR_BPT_W-1:0] bpt;
  } fmt_t;
  typedef struct packed {
    lane_t [`VTR_LANES-1:0] lane;
    fmt_t fmt;
  } vec_word_t;
  typedef struct packed {
    logic force_arith;
    arith_t out_arith;
    logic force_bpt;
    logic [`VTR_BPT_W-1:0] out_bpt;
  } reint_cfg_t;
endpackage

// ===== verif/vtr_sink.sv
// Purpose: downstream sink model, drives out_ready
// Assumes: mode 0 prompt, 1 random stalls, 2 stopped
// Notes: stall pattern from a small lfsr so runs repeat
module vtr_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) lfsr_ff <= 8'h5A;
    else lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
  end
  assign out_ready = (mode == 2'h0) || (mode == 2'h1 && lfsr_ff[0]);
endmodule

// ===== verif/vector_type_reinterpret_tb.sv
// Purpose: self-checking bench for the lane relabel block
// Assumes: sink model stalls the output side
// Notes: expectations are queued at each take, in order
module vector_type_reinterpret_tb
  import vtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, in_valid = 0, in_ready, out_valid, out_ready, bpt_range_err, ok;
  logic [1:0] mode = 2'h0;
  reint_cfg_t cfg = '0;
  vec_word_t in_word = '0, out_word;
  vec_word_t q[$];
  logic [31:0] seed = 32'h53;
  int bad_count = 0, num_checks = 0, n, t, k = 0;
  always #10 clk = ~clk;
  vector_type_reinterpret dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .in_valid(in_valid),
    .in_ready(in_ready), .in_word(in_word), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word), .bpt_range_err(bpt_range_err));
  vtr_sink sink (.clk(clk), .rst_n(rst_n), .mode(mode), .out_ready(out_ready));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic vec_word_t expect_word(vec_word_t w, reint_cfg_t c);
    if (c.force_arith) w.fmt.arith = c.out_arith;
    if (c.force_bpt) w.fmt.bpt = c.out_bpt;
    return w;
  endfunction
  task automatic check(input logic [70:0] seen, input logic [70:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one word offered with fresh random cfg; ok low if refused for lim cycles
  task automatic put(input int lim, output logic fine);
    seed = xs(seed);
    in_word.lane <= {seed, ~seed} ^ {4{16'h8000}};
    in_word.fmt <= {arith_t'(seed[1:0] % 3), 5'(seed[8:4] % 17)};
    seed = xs(seed);
    cfg <= {seed[0], arith_t'(k % 3), seed[3], 5'(seed[8:4] % 17)};
    k++;
    in_valid <= 1'b1;
    t = 0;
    @(negedge clk);
    while (!in_ready && t < lim) begin
      @(negedge clk);
      t++;
    end
    fine = (t < lim);
    @(posedge clk);
  endtask
  // stop offering and let the sink empty the pipeline; bounded so a hang fails
  task automatic drain();
    in_valid <= 1'b0;
    t = 0;
    while (q.size() != 0 && t < 2000) begin
      @(posedge clk);
      t++;
    end
    check(71'(q.size()), 71'h0);
  endtask
  always @(posedge clk) begin
    if (rst_n && in_valid && in_ready) q.push_back(expect_word(in_word, cfg));
    if (rst_n && out_valid && out_ready) begin
      if (q.size() == 0) check(71'h1, 71'h0);
      else check(out_word, q.pop_front());
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    check(71'({in_ready, out_valid, bpt_range_err}), 71'h0);
    check(out_word, '0);
    @(posedge clk);
    rst_n <= 1'b1;
    for (n = 0; n < 60; n++) begin
      if (n == 12) mode <= 2'h1;
      put(300, ok);
      if (!ok) begin
        bad_count++;
        stop_test();
      end
    end
    // empty the pipeline first, else words still buffered eat into the capacity count
    drain();
    // stopped sink: fill until refused, capacity is buffer plus output register
    mode <= 2'h2;
    n = 0;
    ok = 1'b1;
    while (ok && n < 40) begin
      put(20, ok);
      if (ok) n++;
    end
    check(71'(n), 71'h21);
    mode <= 2'h1;
    drain();
    mode <= 2'h0;
    cfg <= {1'b0, ARITH_UNSIGNED, 1'b1, 5'h11};
    @(posedge clk);
    @(negedge clk);
    check(71'(bpt_range_err), 71'h1);
    @(posedge clk);
    cfg <= {1'b0, ARITH_UNSIGNED, 1'b1, 5'h10};
    @(posedge clk);
    @(negedge clk);
    check(71'(bpt_range_err), 71'h0);
    // reset in mid-run with stalled words in flight and a bad point pending
    @(posedge clk);
    mode <= 2'h2;
    for (n = 0; n < 5; n++) begin
      put(20, ok);
      check(71'(ok), 71'h1);
    end
    in_valid <= 1'b0;
    rst_n <= 1'b0;
    cfg <= {1'b0, ARITH_UNSIGNED, 1'b1, 5'h11};
    repeat (2) @(posedge clk);
    q.delete();
    @(negedge clk);
    check(71'({in_ready, out_valid, bpt_range_err}), 71'h0);
    check(out_word, '0);
    @(posedge clk);
    rst_n <= 1'b1;
    mode <= 2'h0;
    @(posedge clk);
    @(negedge clk);
    check(71'({in_ready, out_valid, bpt_range_err}), 71'h5);
    @(posedge clk);
    put(300, ok);
    check(71'(ok), 71'h1);
    drain();
    stop_test();
  end
endmodule
